// [rtl/cdec_defines.svh]
// constants for the compressed instruction decoder
`ifndef CDEC_DEFINES_SVH
`define CDEC_DEFINES_SVH
`define CDEC_XLEN_32 2'h0
`define CDEC_XLEN_64 2'h1
`define CDEC_XLEN_128 2'h2
`define CDEC_Q0 2'h0
`define CDEC_Q1 2'h1
`define CDEC_Q2 2'h2
`define CDEC_Q3 2'h3
`define CDEC_REG_X0 5'h00
`define CDEC_REG_X1 5'h01
`define CDEC_REG_X2 5'h02
`define CDEC_PRIME_HI 2'h1
`define CDEC_ALL_ZERO 16'h0000
`define CDEC_RST_VALID 1'h0
`endif

// [rtl/cdec_pkg.sv]
// types for the compressed instruction decoder
package cdec_pkg;
   typedef enum logic [2:0] {
      CL_NORMAL = 3'h0,
      CL_HINT = 3'h1,
      CL_RESERVED = 3'h2,
      CL_CUSTOM = 3'h3,
      CL_ILLEGAL = 3'h4,
      CL_LONG = 3'h5
   } cdec_cls_t;
   typedef enum logic [5:0] {
      OP_NONE, OP_ADDI4SPN, OP_FLD, OP_LQ, OP_LW, OP_FLW, OP_LD, OP_FSD,
      OP_SQ, OP_SW, OP_FSW, OP_SD, OP_NOP, OP_ADDI, OP_JAL, OP_ADDIW,
      OP_LI, OP_ADDI16SP, OP_LUI, OP_SRLI, OP_SRAI, OP_ANDI, OP_SUB,
      OP_XOR, OP_OR, OP_AND, OP_SUBW, OP_ADDW, OP_J, OP_BEQZ, OP_BNEZ,
      OP_SLLI, OP_FLDSP, OP_LQSP, OP_LWSP, OP_FLWSP, OP_LDSP, OP_JR,
      OP_MV, OP_EBREAK, OP_JALR, OP_ADD, OP_FSDSP, OP_SQSP, OP_SWSP,
      OP_FSWSP, OP_SDSP
   } cdec_op_t;
   typedef struct packed {
      cdec_cls_t cls;
      cdec_op_t op;
      logic [4:0] rd;
      logic [4:0] rs1;
      logic [4:0] rs2;
      logic shift64;
      logic wr_en;
   } cdec_dec_t;
endpackage : cdec_pkg

// [rtl/cdec_decoder.sv]
// single-stage decoder that classifies 16-bit compressed instruction words
`timescale 1ns/10ps
`default_nettype none
`include "cdec_defines.svh"
// What this block does
// - opcode chosen by quadrant bits 1:0 and funct3 bits 15:13
// - words with low bits 11 are longer instructions, not decoded here
// - operand constraints checked; violations become reserved, custom or hint
// - reserved encodings flagged as not implemented
// - custom encodings flagged separately from reserved ones
// - hint encodings identified apart from ordinary instructions
// - shift-left: on RV32 shamt bit 5 is custom, else zero destination is hint
// - zero-shamt shifts are 64-bit shifts on RV128 only, SLLI only with nonzero rd; else hints
// - Q1 funct3 001 is JAL on RV32, ADDIW otherwise, reserved when rd zero
// - LUI zero immediate reserved, zero rd hint, rd 2 selects ADDI16SP
// - Q1 right shifts on RV32 with shamt bit 5 set are custom
// - SUBW and ADDW only on RV64 and RV128; reserved on RV32
// - the all-zero word is always illegal
// - hints change no state beyond the pc; executed as no-ops
module cdec_decoder
   import cdec_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic valid_in,
   input wire logic [15:0] instr_in,
   input wire logic [1:0] xlen_in,
   input wire logic fp_en_in,
   output logic valid_out,
   output cdec_dec_t dec_out,
   output logic illegal_out,
   output logic hint_out
);
   function automatic logic [4:0] prime(input logic [2:0] f);
      prime = {`CDEC_PRIME_HI, f};
   endfunction : prime

   function automatic logic op_writes(input cdec_op_t op);
      unique case (op)
         OP_NONE, OP_FSD, OP_SQ, OP_SW, OP_FSW, OP_SD, OP_NOP, OP_J,
         OP_BEQZ, OP_BNEZ, OP_JR, OP_EBREAK, OP_FSDSP, OP_SQSP,
         OP_SWSP, OP_FSWSP, OP_SDSP: op_writes = 1'h0;
         default: op_writes = 1'h1;
      endcase
   endfunction : op_writes

   function automatic logic is_fp(input cdec_op_t op);
      unique case (op)
         OP_FLD, OP_FSD, OP_FLW, OP_FSW, OP_FLDSP, OP_FSDSP, OP_FLWSP,
         OP_FSWSP: is_fp = 1'h1;
         default: is_fp = 1'h0;
      endcase
   endfunction : is_fp

   logic valid_d;
   logic valid_q;
   cdec_dec_t dec_d;
   cdec_dec_t dec_q;
   logic rv32;
   logic rv128;
   logic rd_nz;
   logic rs2_nz;
   logic imm_nz;
   logic [2:0] f3;

   assign rv32 = (xlen_in == `CDEC_XLEN_32);
   assign rv128 = (xlen_in == `CDEC_XLEN_128);
   assign rd_nz = (instr_in[11:7] != `CDEC_REG_X0);
   assign rs2_nz = (instr_in[6:2] != `CDEC_REG_X0);
   assign imm_nz = ({instr_in[12], instr_in[6:2]} != 6'h00);
   assign f3 = instr_in[15:13];

   always_comb begin
      dec_d = '0;
      dec_d.cls = CL_NORMAL;
      dec_d.op = OP_NONE;
      dec_d.rd = instr_in[11:7];
      dec_d.rs1 = instr_in[11:7];
      dec_d.rs2 = instr_in[6:2];
      valid_d = valid_in;
      unique case (instr_in[1:0])
         `CDEC_Q0: begin
            dec_d.rd = prime(instr_in[4:2]);
            dec_d.rs1 = prime(instr_in[9:7]);
            dec_d.rs2 = prime(instr_in[4:2]);
            unique case (f3)
               3'h0: begin
                  dec_d.op = OP_ADDI4SPN;
                  dec_d.rs1 = `CDEC_REG_X2;
                  if (instr_in[12:5] == 8'h00) begin
                     dec_d.cls = CL_RESERVED;
                  end
               end
               3'h1: dec_d.op = rv128 ? OP_LQ : OP_FLD;
               3'h2: dec_d.op = OP_LW;
               3'h3: dec_d.op = rv32 ? OP_FLW : OP_LD;
               3'h4: dec_d.cls = CL_RESERVED;
               3'h5: dec_d.op = rv128 ? OP_SQ : OP_FSD;
               3'h6: dec_d.op = OP_SW;
               3'h7: dec_d.op = rv32 ? OP_FSW : OP_SD;
            endcase
         end
         `CDEC_Q1: begin
            unique case (f3)
               3'h0: begin
                  if (!rd_nz) begin
                     dec_d.op = OP_NOP;
                     if (imm_nz) begin
                        dec_d.cls = CL_HINT;
                     end
                  end else begin
                     dec_d.op = OP_ADDI;
                     if (!imm_nz) begin
                        dec_d.cls = CL_HINT;
                     end
                  end
               end
               3'h1: begin
                  if (rv32) begin
                     dec_d.op = OP_JAL;
                     dec_d.rd = `CDEC_REG_X1;
                  end else begin
                     dec_d.op = OP_ADDIW;
                     if (!rd_nz) begin
                        dec_d.cls = CL_RESERVED;
                     end
                  end
               end
               3'h2: begin
                  dec_d.op = OP_LI;
                  dec_d.rs1 = `CDEC_REG_X0;
                  if (!rd_nz) begin
                     dec_d.cls = CL_HINT;
                  end
               end
               3'h3: begin
                  if (instr_in[11:7] == `CDEC_REG_X2) begin
                     dec_d.op = OP_ADDI16SP;
                     if (!imm_nz) begin
                        dec_d.cls = CL_RESERVED;
                     end
                  end else begin
                     dec_d.op = OP_LUI;
                     if (!imm_nz) begin
                        dec_d.cls = CL_RESERVED;
                     end else if (!rd_nz) begin
                        dec_d.cls = CL_HINT;
                     end
                  end
               end
               3'h4: begin
                  dec_d.rd = prime(instr_in[9:7]);
                  dec_d.rs1 = prime(instr_in[9:7]);
                  dec_d.rs2 = prime(instr_in[4:2]);
                  unique case (instr_in[11:10])
                     2'h0, 2'h1: begin
                        dec_d.op = instr_in[10] ? OP_SRAI : OP_SRLI;
                        if (!imm_nz) begin
                           if (rv128) begin
                              dec_d.shift64 = 1'h1;
                           end else begin
                              dec_d.cls = CL_HINT;
                           end
                        end else if (rv32 && instr_in[12]) begin
                           dec_d.cls = CL_CUSTOM;
                        end
                     end
                     2'h2: dec_d.op = OP_ANDI;
                     2'h3: begin
                        if (!instr_in[12]) begin
                           unique case (instr_in[6:5])
                              2'h0: dec_d.op = OP_SUB;
                              2'h1: dec_d.op = OP_XOR;
                              2'h2: dec_d.op = OP_OR;
                              2'h3: dec_d.op = OP_AND;
                           endcase
                        end else if (!instr_in[6]) begin
                           dec_d.op = instr_in[5] ? OP_ADDW : OP_SUBW;
                           if (rv32) begin
                              dec_d.cls = CL_RESERVED;
                           end
                        end else begin
                           dec_d.cls = CL_RESERVED;
                        end
                     end
                  endcase
               end
               3'h5: begin
                  dec_d.op = OP_J;
                  dec_d.rd = `CDEC_REG_X0;
               end
               3'h6, 3'h7: begin
                  dec_d.op = f3[0] ? OP_BNEZ : OP_BEQZ;
                  dec_d.rs1 = prime(instr_in[9:7]);
                  dec_d.rs2 = `CDEC_REG_X0;
               end
            endcase
         end
         `CDEC_Q2: begin
            unique case (f3)
               3'h0: begin
                  dec_d.op = OP_SLLI;
                  if (!imm_nz) begin
                     if (rv128 && rd_nz) begin
                        dec_d.shift64 = 1'h1;
                     end else begin
                        dec_d.cls = CL_HINT;
                     end
                  end else if (rv32 && instr_in[12]) begin
                     dec_d.cls = CL_CUSTOM;
                  end else if (!rd_nz) begin
                     dec_d.cls = CL_HINT;
                  end
               end
               3'h1, 3'h2, 3'h3: begin
                  dec_d.rs1 = `CDEC_REG_X2;
                  if (f3 == 3'h2) begin
                     dec_d.op = OP_LWSP;
                  end else if (f3 == 3'h1) begin
                     dec_d.op = rv128 ? OP_LQSP : OP_FLDSP;
                  end else begin
                     dec_d.op = rv32 ? OP_FLWSP : OP_LDSP;
                  end
                  if (!rd_nz && !is_fp(dec_d.op)) begin
                     dec_d.cls = CL_RESERVED;
                  end
               end
               3'h4: begin
                  if (!instr_in[12]) begin
                     if (!rs2_nz) begin
                        dec_d.op = OP_JR;
                        dec_d.rd = `CDEC_REG_X0;
                        if (!rd_nz) begin
                           dec_d.cls = CL_RESERVED;
                        end
                     end else begin
                        dec_d.op = OP_MV;
                        dec_d.rs1 = `CDEC_REG_X0;
                        if (!rd_nz) begin
                           dec_d.cls = CL_HINT;
                        end
                     end
                  end else if (!rs2_nz) begin
                     dec_d.op = rd_nz ? OP_JALR : OP_EBREAK;
                     dec_d.rd = `CDEC_REG_X1;
                  end else begin
                     dec_d.op = OP_ADD;
                     if (!rd_nz) begin
                        dec_d.cls = CL_HINT;
                     end
                  end
               end
               3'h5: dec_d.op = rv128 ? OP_SQSP : OP_FSDSP;
               3'h6: dec_d.op = OP_SWSP;
               3'h7: dec_d.op = rv32 ? OP_FSWSP : OP_SDSP;
            endcase
            if (f3 >= 3'h5) begin
               dec_d.rs1 = `CDEC_REG_X2;
            end
         end
         `CDEC_Q3: dec_d.cls = CL_LONG;
      endcase
      // fp encodings without fp support cannot run, so they trap
      if (is_fp(dec_d.op) && !fp_en_in && dec_d.cls == CL_NORMAL) begin
         dec_d.cls = CL_ILLEGAL;
      end
      if (instr_in == `CDEC_ALL_ZERO) begin
         dec_d.cls = CL_ILLEGAL;
      end
      // a hint never writes, so the pipeline runs it as a no-op
      dec_d.wr_en = (dec_d.cls == CL_NORMAL) && op_writes(dec_d.op);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         valid_q <= `CDEC_RST_VALID;
         dec_q <= '0;
      end else begin
         valid_q <= valid_d;
         dec_q <= dec_d;
      end
   end

   assign valid_out = valid_q;
   assign dec_out = dec_q;
   assign illegal_out = valid_q && (dec_q.cls == CL_RESERVED || dec_q.cls == CL_CUSTOM
                        || dec_q.cls == CL_ILLEGAL);
   assign hint_out = valid_q && (dec_q.cls == CL_HINT);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   zero_word_a: assert property (valid_in && instr_in == 16'h0000 |=>
      illegal_out && dec_out.cls == CL_ILLEGAL)
      else $error("all-zero word not illegal");
   long_word_a: assert property (valid_in && instr_in[1:0] == 2'h3 |=>
      dec_out.cls == CL_LONG && !illegal_out && !dec_out.wr_en)
      else $error("long word decoded as compressed");
   reserved_flag_a: assert property (valid_out && dec_out.cls == CL_RESERVED |->
      illegal_out && !hint_out)
      else $error("reserved not flagged");
   custom_flag_a: assert property (valid_out && dec_out.cls == CL_CUSTOM |->
      illegal_out && !dec_out.wr_en)
      else $error("custom not flagged");
   hint_quiet_a: assert property (hint_out |-> !dec_out.wr_en && !illegal_out)
      else $error("hint writes state");
   slli_custom_a: assert property (valid_in && instr_in[1:0] == 2'h2 && f3 == 3'h0
      && rv32 && instr_in[12] |=> dec_out.cls == CL_CUSTOM)
      else $error("rv32 slli shamt5 not custom");
   shift64_a: assert property (valid_in && instr_in[1:0] == 2'h1 && f3 == 3'h4
      && !instr_in[11] && !imm_nz |=> dec_out.shift64 == $past(rv128)
      && hint_out == !$past(rv128))
      else $error("zero-shamt shift misclassified");
   addiw_res_a: assert property (valid_in && instr_in[1:0] == 2'h1 && f3 == 3'h1
      && !rv32 && !rd_nz && instr_in != 16'h0000 |=> dec_out.cls == CL_RESERVED)
      else $error("addiw rd0 not reserved");
   lui_res_a: assert property (valid_in && instr_in[1:0] == 2'h1 && f3 == 3'h3
      && instr_in[11:7] != 5'h02 && !imm_nz |=> dec_out.cls == CL_RESERVED)
      else $error("lui zero imm not reserved");
   srx_custom_a: assert property (valid_in && instr_in[1:0] == 2'h1 && f3 == 3'h4
      && !instr_in[11] && rv32 && instr_in[12] |=> dec_out.cls == CL_CUSTOM)
      else $error("rv32 right shift shamt5 not custom");
   addw_rv32_a: assert property (valid_in && instr_in[1:0] == 2'h1 && f3 == 3'h4
      && instr_in[12:10] == 3'h7 && !instr_in[6] |=> illegal_out == $past(rv32))
      else $error("subw/addw width check wrong");
   prime_map_a: assert property (valid_out && dec_out.op == OP_SUB |->
      dec_out.rd[4:3] == 2'h1 && dec_out.rs2[4:3] == 2'h1)
      else $error("prime register not mapped");
   hint_cover_c: cover property (hint_out);
   custom_cover_c: cover property (valid_out && dec_out.cls == CL_CUSTOM);
   shift64_cover_c: cover property (valid_out && dec_out.shift64);
   normal_cover_c: cover property (valid_out && dec_out.wr_en);
endmodule : cdec_decoder
`default_nettype wire

// [bench/cdec_fetch_model.sv]
// fetch-side model that presents one compressed word per cycle to the decoder
`timescale 1ns/10ps
`default_nettype none
module cdec_fetch_model
   import cdec_pkg::*;
(
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [15:0] word_in,
   output logic valid_out,
   output logic [15:0] instr_out
);
   logic [15:0] last_q;
   logic [15:0] last_d;
   always_comb begin
      last_d = go_in ? word_in : last_q;
   end
   always_ff @(posedge clk_in) begin
      last_q <= last_d;
   end
   // idle bus shows the inverse of the last word, so a stale word is never decoded by luck
   assign valid_out = go_in;
   assign instr_out = go_in ? word_in : ~last_q;
endmodule : cdec_fetch_model
`default_nettype wire

// [bench/tb_cdec_decoder.sv]
// self-checking testbench for the compressed instruction decoder
`timescale 1ns/10ps
`default_nettype none
module tb_cdec_decoder
   import cdec_pkg::*;
;
   logic clk_in;
   logic sys_rst_in;
   logic go;
   logic [15:0] word;
   logic [1:0] xlen;
   logic fp_en;
   logic valid_in;
   logic [15:0] instr_in;
   logic valid_out;
   cdec_dec_t dec_out;
   logic illegal_out;
   logic hint_out;
   int n_errors;
   int n_compared;
   int n_cycles;
   cdec_fetch_model i_fetch (.clk_in(clk_in), .go_in(go), .word_in(word),
      .valid_out(valid_in), .instr_out(instr_in));
   cdec_decoder i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .valid_in(valid_in),
      .instr_in(instr_in), .xlen_in(xlen), .fp_en_in(fp_en), .valid_out(valid_out),
      .dec_out(dec_out), .illegal_out(illegal_out), .hint_out(hint_out));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   task automatic end_sim();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   // a hang would otherwise hold the run forever; the tests need about 94 cycles
   always @(posedge clk_in) begin
      n_cycles++;
      if (n_cycles == 2000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // called at a falling edge; the word stays valid until the next call or idle
   task automatic run(input logic [15:0] w, input logic [1:0] x, input logic f,
                      input cdec_cls_t c, input cdec_op_t o);
      logic bad;
      go = 1'b1;
      word = w;
      xlen = x;
      fp_en = f;
      bad = (c == CL_RESERVED) || (c == CL_CUSTOM) || (c == CL_ILLEGAL);
      @(negedge clk_in);
      chk("valid", 32'(valid_out), 32'h1);
      chk("class", 32'(dec_out.cls), 32'(c));
      if (o != OP_NONE) chk("op", 32'(dec_out.op), 32'(o));
      chk("illegal", 32'(illegal_out), 32'(bad));
      chk("hint", 32'(hint_out), 32'(c == CL_HINT));
      if (c != CL_NORMAL) chk("wr_en", 32'(dec_out.wr_en), 32'h0);
   endtask : run
   task automatic regs(input logic [4:0] rd, input logic [4:0] rs1);
      chk("rd", 32'(dec_out.rd), 32'(rd));
      chk("rs1", 32'(dec_out.rs1), 32'(rs1));
   endtask : regs
   task automatic t_map();
      run(16'h4501, 2'h1, 1'b1, CL_NORMAL, OP_LI);
      regs(5'h0a, 5'h00);
      run(16'h4188, 2'h1, 1'b1, CL_NORMAL, OP_LW);
      regs(5'h0a, 5'h0b);
      run(16'h6000, 2'h0, 1'b1, CL_NORMAL, OP_FLW);
      run(16'h6000, 2'h0, 1'b0, CL_ILLEGAL, OP_NONE);
      run(16'h6000, 2'h1, 1'b1, CL_NORMAL, OP_LD);
   endtask : t_map
   task automatic t_long_zero();
      run(16'hffff, 2'h1, 1'b1, CL_LONG, OP_NONE);
      run(16'h0013, 2'h0, 1'b1, CL_LONG, OP_NONE);
      for (int i = 0; i < 3; i++) begin
         run(16'h0000, 2'(i), 1'b1, CL_ILLEGAL, OP_NONE);
      end
   endtask : t_long_zero
   task automatic t_hint_res();
      run(16'h0005, 2'h1, 1'b1, CL_HINT, OP_NONE);
      run(16'h4001, 2'h1, 1'b1, CL_HINT, OP_NONE);
      run(16'h802a, 2'h1, 1'b1, CL_HINT, OP_NONE);
      run(16'h0501, 2'h1, 1'b1, CL_HINT, OP_NONE);
      run(16'h8000, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h4002, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h8002, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h0004, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h9c41, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
   endtask : t_hint_res
   task automatic t_shifts();
      run(16'h0506, 2'h1, 1'b1, CL_NORMAL, OP_SLLI);
      run(16'h0006, 2'h1, 1'b1, CL_HINT, OP_NONE);
      run(16'h1506, 2'h0, 1'b1, CL_CUSTOM, OP_NONE);
      run(16'h1506, 2'h1, 1'b1, CL_NORMAL, OP_SLLI);
      run(16'h0502, 2'h2, 1'b1, CL_NORMAL, OP_SLLI);
      chk("shift64", 32'(dec_out.shift64), 32'h1);
      run(16'h0502, 2'h1, 1'b1, CL_HINT, OP_NONE);
      run(16'h0502, 2'h0, 1'b1, CL_HINT, OP_NONE);
      run(16'h0002, 2'h2, 1'b1, CL_HINT, OP_NONE);
      run(16'h8005, 2'h0, 1'b1, CL_NORMAL, OP_SRLI);
      regs(5'h08, 5'h08);
      run(16'h9005, 2'h0, 1'b1, CL_CUSTOM, OP_NONE);
      run(16'h9405, 2'h0, 1'b1, CL_CUSTOM, OP_NONE);
      run(16'h9405, 2'h1, 1'b1, CL_NORMAL, OP_SRAI);
      run(16'h8001, 2'h2, 1'b1, CL_NORMAL, OP_SRLI);
      chk("shift64", 32'(dec_out.shift64), 32'h1);
      run(16'h8001, 2'h0, 1'b1, CL_HINT, OP_NONE);
      run(16'h8401, 2'h1, 1'b1, CL_HINT, OP_NONE);
   endtask : t_shifts
   task automatic t_width();
      run(16'h2505, 2'h0, 1'b1, CL_NORMAL, OP_JAL);
      run(16'h2505, 2'h1, 1'b1, CL_NORMAL, OP_ADDIW);
      run(16'h2505, 2'h2, 1'b1, CL_NORMAL, OP_ADDIW);
      run(16'h2005, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h2005, 2'h0, 1'b1, CL_NORMAL, OP_JAL);
      run(16'h6505, 2'h1, 1'b1, CL_NORMAL, OP_LUI);
      run(16'h6501, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h6005, 2'h1, 1'b1, CL_HINT, OP_NONE);
      run(16'h6001, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h6105, 2'h1, 1'b1, CL_NORMAL, OP_ADDI16SP);
      run(16'h6101, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h9c05, 2'h0, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h9c25, 2'h0, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h9c05, 2'h1, 1'b1, CL_NORMAL, OP_SUBW);
      run(16'h9c25, 2'h2, 1'b1, CL_NORMAL, OP_ADDW);
   endtask : t_width
   // one word of each remaining op, with the register fields the pipeline reads
   task automatic t_ops();
      run(16'h8c89, 2'h1, 1'b1, CL_NORMAL, OP_SUB);
      regs(5'h09, 5'h09);
      chk("rs2", 32'(dec_out.rs2), 32'h0a);
      chk("wr_en", 32'(dec_out.wr_en), 32'h1);
      run(16'h8c25, 2'h1, 1'b1, CL_NORMAL, OP_XOR);
      run(16'h8c45, 2'h1, 1'b1, CL_NORMAL, OP_OR);
      run(16'h8c65, 2'h1, 1'b1, CL_NORMAL, OP_AND);
      run(16'h8805, 2'h1, 1'b1, CL_NORMAL, OP_ANDI);
      run(16'h0505, 2'h1, 1'b1, CL_NORMAL, OP_ADDI);
      run(16'h0001, 2'h1, 1'b1, CL_NORMAL, OP_NOP);
      run(16'h0020, 2'h1, 1'b1, CL_NORMAL, OP_ADDI4SPN);
      regs(5'h08, 5'h02);
      run(16'ha001, 2'h1, 1'b1, CL_NORMAL, OP_J);
      run(16'hc001, 2'h1, 1'b1, CL_NORMAL, OP_BEQZ);
      chk("rs1", 32'(dec_out.rs1), 32'h08);
      run(16'he381, 2'h1, 1'b1, CL_NORMAL, OP_BNEZ);
      chk("rs1", 32'(dec_out.rs1), 32'h0f);
      chk("wr_en", 32'(dec_out.wr_en), 32'h0);
      run(16'h9002, 2'h1, 1'b1, CL_NORMAL, OP_EBREAK);
      chk("wr_en", 32'(dec_out.wr_en), 32'h0);
      run(16'h9082, 2'h1, 1'b1, CL_NORMAL, OP_JALR);
      regs(5'h01, 5'h01);
      run(16'h8082, 2'h1, 1'b1, CL_NORMAL, OP_JR);
      run(16'h8506, 2'h1, 1'b1, CL_NORMAL, OP_MV);
      regs(5'h0a, 5'h00);
      run(16'h9506, 2'h1, 1'b1, CL_NORMAL, OP_ADD);
      chk("rs2", 32'(dec_out.rs2), 32'h01);
      run(16'h9006, 2'h1, 1'b1, CL_HINT, OP_NONE);
      run(16'hc000, 2'h1, 1'b1, CL_NORMAL, OP_SW);
      chk("wr_en", 32'(dec_out.wr_en), 32'h0);
      run(16'he000, 2'h0, 1'b1, CL_NORMAL, OP_FSW);
      run(16'he000, 2'h1, 1'b1, CL_NORMAL, OP_SD);
      run(16'ha000, 2'h1, 1'b1, CL_NORMAL, OP_FSD);
      run(16'ha000, 2'h2, 1'b1, CL_NORMAL, OP_SQ);
      run(16'h2000, 2'h1, 1'b1, CL_NORMAL, OP_FLD);
      run(16'h2000, 2'h2, 1'b1, CL_NORMAL, OP_LQ);
      run(16'hc002, 2'h1, 1'b1, CL_NORMAL, OP_SWSP);
      chk("rs1", 32'(dec_out.rs1), 32'h02);
      run(16'he002, 2'h0, 1'b1, CL_NORMAL, OP_FSWSP);
      run(16'he002, 2'h1, 1'b1, CL_NORMAL, OP_SDSP);
      run(16'ha002, 2'h1, 1'b1, CL_NORMAL, OP_FSDSP);
      run(16'ha002, 2'h2, 1'b1, CL_NORMAL, OP_SQSP);
      run(16'ha002, 2'h1, 1'b0, CL_ILLEGAL, OP_NONE);
      run(16'h2002, 2'h1, 1'b1, CL_NORMAL, OP_FLDSP);
      run(16'h2002, 2'h2, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h2502, 2'h2, 1'b1, CL_NORMAL, OP_LQSP);
      run(16'h6002, 2'h0, 1'b1, CL_NORMAL, OP_FLWSP);
      run(16'h6002, 2'h1, 1'b1, CL_RESERVED, OP_NONE);
      run(16'h6502, 2'h1, 1'b1, CL_NORMAL, OP_LDSP);
      run(16'h4502, 2'h1, 1'b1, CL_NORMAL, OP_LWSP);
      regs(5'h0a, 5'h02);
   endtask : t_ops
   task automatic t_idle_reset();
      go = 1'b0;
      @(negedge clk_in);
      chk("idle valid", 32'(valid_out), 32'h0);
      chk("idle illegal", 32'(illegal_out), 32'h0);
      chk("idle hint", 32'(hint_out), 32'h0);
      go = 1'b1;
      word = 16'h0000;
      sys_rst_in = 1'b1;
      @(negedge clk_in);
      chk("reset valid", 32'(valid_out), 32'h0);
      chk("reset illegal", 32'(illegal_out), 32'h0);
      chk("reset dec", 32'(dec_out), 32'h0);
      sys_rst_in = 1'b0;
   endtask : t_idle_reset
   initial begin
      n_errors = 0;
      n_compared = 0;
      n_cycles = 0;
      sys_rst_in = 1'b1;
      go = 1'b0;
      word = 16'h0000;
      xlen = 2'h0;
      fp_en = 1'b1;
      repeat (5) @(negedge clk_in);
      chk("reset valid", 32'(valid_out), 32'h0);
      chk("reset dec", 32'(dec_out), 32'h0);
      sys_rst_in = 1'b0;
      t_map();
      t_long_zero();
      t_hint_res();
      t_shifts();
      t_width();
      t_ops();
      t_idle_reset();
      run(16'h0000, 2'h1, 1'b1, CL_ILLEGAL, OP_NONE);
      end_sim();
   end
endmodule : tb_cdec_decoder
`default_nettype wire
